// ### aci_engine.v
// ATA command engine: idle/power, reads, verify, recalibrate,
// geometry setup, security disable, identify words 54..255.
// Assumes a host-side transport feeding task-file fields and moving
// 16-bit data words; flash access is a word stream with ECC flag.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`include "aci_map.vh"
`default_nettype none
module aci_engine #(
  parameter [31:0] TOTAL_SECTORS = 32'h0000_0000,
  parameter [7:0] INTEGRITY_SIG = 8'hA5
) (
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  input wire cmdValid,
  input wire [7:0] cmdCode,
  input wire [7:0] cmdFeature,
  input wire [7:0] cmdCount,
  input wire [7:0] cmdSector,
  input wire [15:0] cmdCyl,
  input wire [3:0] cmdHead,
  input wire hostWrValid,
  input wire [15:0] hostWrData,
  input wire flashValid,
  input wire [15:0] flashData,
  input wire flashEccErr,
  input wire secEnableIn,
  input wire smartEnableIn,
  output reg busyOut,
  output reg drqOut,
  output reg dmaActOut,
  output reg intrPulse,
  output reg errOut,
  output reg hostRdValid,
  output reg [15:0] hostRdData,
  output reg flashReq,
  output reg [7:0] flashSector,
  output reg [15:0] flashCyl,
  output reg [3:0] flashHead,
  output reg idleMode,
  output reg autoPdEn,
  output reg [7:0] geoSpt,
  output reg [3:0] geoHeads,
  output reg userPwdActive,
  output reg lockedOut
);
// =========================================================
// State
localparam [2:0] S_IDLE = 3'd0;
localparam [2:0] S_FETCH = 3'd1;
localparam [2:0] S_DATA = 3'd2;
localparam [2:0] S_IDENT = 3'd3;
localparam [2:0] S_PWD = 3'd4;
localparam [2:0] S_DONE = 3'd5;
reg [2:0] state_r;
reg [8:0] secLeft_r;
reg [8:0] wordCnt_r;
reg [7:0] blkCnt_r;
reg noData_r;
reg isMul_r;
reg pwdMatch_r;
reg [7:0] multSet_r;
reg multValid_r;
reg [2:0] mwSel_r;
reg [4:0] udSel_r;
reg lookAhead_r;
reg wcache_r;
reg [255:0] userPwd_r;
reg [255:0] masterPwd_r;
reg useMaster_r;
reg [7:0] cks_r;
wire [8:0] reqSecs = (cmdCount == 8'h00) ? 9'h100 : {1'b0, cmdCount};
wire [7:0] blkSize = (multSet_r == 8'h00) ? 8'h01 : multSet_r;
// =========================================================
// Identify word table
reg [15:0] idWord;
always @* begin
  case (wordCnt_r[7:0])
    8'd59: idWord = {7'h00, multValid_r, multSet_r};
    8'd60: idWord = TOTAL_SECTORS[15:0];
    8'd61: idWord = TOTAL_SECTORS[31:16];
    8'd63: idWord = {5'h00, mwSel_r, 8'h07};
    8'd64: idWord = `ACI_W64;
    8'd65, 8'd66, 8'd67, 8'd68: idWord = `ACI_WCYC;
    8'd80: idWord = `ACI_W80;
    8'd81: idWord = `ACI_W81;
    8'd82: idWord = `ACI_W82;
    8'd83: idWord = `ACI_W83;
    8'd84: idWord = `ACI_W84;
    8'd85: idWord = {9'h000, lookAhead_r, wcache_r, 3'b010,
                     secEnableIn, smartEnableIn};
    8'd86: idWord = `ACI_W86;
    8'd87: idWord = `ACI_W87;
    8'd88: idWord = {3'b001, udSel_r, 8'h3F};
    8'd128: idWord = {7'h00, 1'b0, 3'b000, 1'b0, 1'b0,
                      lockedOut, userPwdActive, 1'b1};
    8'd255: idWord = {cks_r - INTEGRITY_SIG, INTEGRITY_SIG};
    default: idWord = 16'h0000; // Words below 54 come from elsewhere
  endcase
end
// Checksum makes all bytes sum to zero including itself.
wire [7:0] cksNext = cks_r - idWord[15:8] - idWord[7:0];
wire [8:0] pwdIdx = wordCnt_r - 9'h001;
// =========================================================
// Sequencer
always @(posedge core_clk or negedge rst_n) begin
  if (!rst_n) begin
    state_r <= S_IDLE;
    busyOut <= 1'b0;
    drqOut <= 1'b0;
    dmaActOut <= 1'b0;
    intrPulse <= 1'b0;
    errOut <= 1'b0;
    hostRdValid <= 1'b0;
    hostRdData <= 16'h0000;
    flashReq <= 1'b0;
    flashSector <= 8'h00;
    flashCyl <= 16'h0000;
    flashHead <= 4'h0;
    idleMode <= 1'b0;
    autoPdEn <= 1'b0;
    geoSpt <= 8'h00;
    geoHeads <= 4'h0;
    userPwdActive <= 1'b0;
    lockedOut <= 1'b0;
    secLeft_r <= 9'h000;
    wordCnt_r <= 9'h000;
    blkCnt_r <= 8'h00;
    noData_r <= 1'b0;
    isMul_r <= 1'b0;
    pwdMatch_r <= 1'b0;
    multSet_r <= 8'h00;
    multValid_r <= 1'b0;
    mwSel_r <= 3'b000;
    udSel_r <= 5'b00000;
    lookAhead_r <= 1'b0;
    wcache_r <= 1'b0;
    userPwd_r <= 256'h0;
    masterPwd_r <= 256'h0;
    useMaster_r <= 1'b0;
    cks_r <= 8'h00;
  end else if (clkEn) begin
    intrPulse <= 1'b0;
    hostRdValid <= 1'b0;
    flashReq <= 1'b0;
    case (state_r)
      S_IDLE: begin
        if (cmdValid) begin
          busyOut <= 1'b1;
          errOut <= 1'b0;
          wordCnt_r <= 9'h000;
          state_r <= S_DONE;
          case (cmdCode)
            `ACI_CMD_IDLE: begin
              idleMode <= 1'b1;
              autoPdEn <= (cmdCount != 8'h00);
            end
            `ACI_CMD_IDLEIMM: idleMode <= 1'b1;
            `ACI_CMD_INITPAR: begin
              geoSpt <= cmdCount;
              geoHeads <= cmdHead;
            end
            `ACI_CMD_RECAL: ;
            `ACI_CMD_SETMUL: begin
              multSet_r <= cmdCount;
              multValid_r <= (cmdCount != 8'h00);
            end
            `ACI_CMD_SETFEAT: begin
              case (cmdFeature)
                `ACI_FT_XFER: begin
                  if (cmdCount[7:3] == 5'b00100) begin
                    mwSel_r <= 3'b001 << cmdCount[1:0];
                    udSel_r <= 5'b00000;
                  end else if (cmdCount[7:3] == 5'b01000) begin
                    udSel_r <= 5'b00001 << cmdCount[2:0];
                    mwSel_r <= 3'b000;
                  end
                end
                `ACI_FT_WCEN: wcache_r <= 1'b1;
                `ACI_FT_WCDIS: wcache_r <= 1'b0;
                `ACI_FT_LAEN: lookAhead_r <= 1'b1;
                `ACI_FT_LADIS: lookAhead_r <= 1'b0;
                default: errOut <= 1'b1;
              endcase
            end
            `ACI_CMD_RDSEC, `ACI_CMD_RDSEC2, `ACI_CMD_RDMUL,
            `ACI_CMD_RDDMA, `ACI_CMD_RDDMA2,
            `ACI_CMD_VERIFY, `ACI_CMD_VERIFY2: begin
              secLeft_r <= reqSecs;
              flashSector <= cmdSector;
              flashCyl <= cmdCyl;
              flashHead <= cmdHead;
              noData_r <= (cmdCode == `ACI_CMD_VERIFY) ||
                          (cmdCode == `ACI_CMD_VERIFY2);
              isMul_r <= (cmdCode == `ACI_CMD_RDMUL) ||
                         (cmdCode == `ACI_CMD_RDDMA) ||
                         (cmdCode == `ACI_CMD_RDDMA2);
              // DMA needs a selected mode; unset means abort
              if ((cmdCode == `ACI_CMD_RDDMA ||
                   cmdCode == `ACI_CMD_RDDMA2) &&
                  mwSel_r == 3'b000 && udSel_r == 5'b00000)
                errOut <= 1'b1;
              else begin
                dmaActOut <= (cmdCode == `ACI_CMD_RDDMA) ||
                             (cmdCode == `ACI_CMD_RDDMA2);
                blkCnt_r <= 8'h00;
                flashReq <= 1'b1;
                state_r <= S_FETCH;
              end
            end
            `ACI_CMD_IDENT: begin
              drqOut <= 1'b1;
              cks_r <= 8'h00;
              state_r <= S_IDENT;
            end
            `ACI_CMD_SECDIS: begin
              drqOut <= 1'b1;
              pwdMatch_r <= 1'b1;
              state_r <= S_PWD;
            end
            default: errOut <= 1'b1;
          endcase
        end
      end
      S_FETCH: begin
        // Wait for the first word of the sector from flash
        if (flashValid) begin
          wordCnt_r <= 9'h001;
          drqOut <= ~noData_r & ~dmaActOut;
          hostRdValid <= ~noData_r;
          hostRdData <= flashData;
          if (flashEccErr)
            errOut <= 1'b1;
          state_r <= S_DATA;
        end
      end
      S_DATA: begin
        if (flashValid) begin
          hostRdValid <= ~noData_r;
          hostRdData <= flashData;
          if (flashEccErr)
            errOut <= 1'b1;
          wordCnt_r <= wordCnt_r + 9'h001;
          if (wordCnt_r == `ACI_SECT_WORDS - 9'h001) begin
            secLeft_r <= secLeft_r - 9'h001;
            flashSector <= flashSector + 8'h01;
            blkCnt_r <= blkCnt_r + 8'h01;
            drqOut <= 1'b0;
            // Per-block interrupt for PIO multiple, per sector for single reads; none for DMA or verify
            if (!isMul_r && !noData_r && secLeft_r != 9'h001)
              intrPulse <= 1'b1;
            else if (isMul_r && !dmaActOut &&
                     blkCnt_r + 8'h01 == blkSize &&
                     secLeft_r != 9'h001) begin
              intrPulse <= 1'b1;
              blkCnt_r <= 8'h00;
            end
            if (secLeft_r == 9'h001 || flashEccErr)
              state_r <= S_DONE;
            else begin
              flashReq <= 1'b1;
              state_r <= S_FETCH;
            end
          end
        end
      end
      S_IDENT: begin
        hostRdValid <= 1'b1;
        hostRdData <= idWord;
        cks_r <= cksNext;
        if (wordCnt_r[7:0] == 8'hFF)
          state_r <= S_DONE;
        wordCnt_r <= wordCnt_r + 9'h001;
      end
      S_PWD: begin
        if (hostWrValid) begin
          wordCnt_r <= wordCnt_r + 9'h001;
          if (wordCnt_r == 9'h000)
            useMaster_r <= hostWrData[0];
          else if (wordCnt_r <= `ACI_PWD_WORDS) begin
            if (hostWrData != (useMaster_r ?
                masterPwd_r[pwdIdx[3:0]*16 +: 16] :
                userPwd_r[pwdIdx[3:0]*16 +: 16]))
              pwdMatch_r <= 1'b0;
          end
          if (wordCnt_r == `ACI_SECT_WORDS - 9'h001) begin
            drqOut <= 1'b0;
            state_r <= S_DONE;
            if (pwdMatch_r) begin
              userPwdActive <= 1'b0;
              lockedOut <= 1'b0;
            end else
              errOut <= 1'b1;
          end
        end
      end
      S_DONE: begin
        busyOut <= 1'b0;
        drqOut <= 1'b0;
        dmaActOut <= 1'b0;
        intrPulse <= 1'b1;
        state_r <= S_IDLE;
      end
      default: state_r <= S_IDLE;
    endcase
  end
end
endmodule
`default_nettype wire

// ### aci_map.vh
// Command codes, identify layout constants and word counts.
// Assumes inclusion by the command engine only.
`ifndef ACI_MAP_VH
`define ACI_MAP_VH
`define ACI_CMD_IDLE 8'hE3
`define ACI_CMD_IDLEIMM 8'hE1
`define ACI_CMD_INITPAR 8'h91
`define ACI_CMD_RDDMA 8'hC8
`define ACI_CMD_RDDMA2 8'hC9
`define ACI_CMD_RDMUL 8'hC4
`define ACI_CMD_RDSEC 8'h20
`define ACI_CMD_RDSEC2 8'h21
`define ACI_CMD_VERIFY 8'h40
`define ACI_CMD_VERIFY2 8'h41
`define ACI_CMD_RECAL 8'h10
`define ACI_CMD_SECDIS 8'hF6
`define ACI_CMD_SECSET 8'hF1
`define ACI_CMD_IDENT 8'hEC
`define ACI_CMD_SETFEAT 8'hEF
`define ACI_CMD_SETMUL 8'hC6
`define ACI_FT_XFER 8'h03
`define ACI_FT_WCEN 8'h02
`define ACI_FT_WCDIS 8'h82
`define ACI_FT_LADIS 8'h55
`define ACI_FT_LAEN 8'hAA
`define ACI_W59_RST 16'h0000
`define ACI_W63_RST 16'h0007
`define ACI_W64 16'h0003
`define ACI_WCYC 16'h0078
`define ACI_W80 16'h01FE
`define ACI_W81 16'h0021
`define ACI_W82 16'h0068
`define ACI_W83 16'h5000
`define ACI_W84 16'h4000
`define ACI_W85_RST 16'h0008
`define ACI_W86 16'h5000
`define ACI_W87 16'h4000
`define ACI_W88_RST 16'h203F
`define ACI_W128_RST 16'h0001
`define ACI_SECT_WORDS 9'h100
`define ACI_PWD_WORDS 9'h010
`endif

// ### aci_engine_asserts.sv
// Port checker for the command engine.
// Assumes it is bound to every engine instance.
`default_nettype none
// ==========
// Checker
module aci_engine_asserts (
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  input wire cmdValid,
  input wire [7:0] cmdCode,
  input wire [7:0] cmdCount,
  input wire [7:0] cmdSector,
  input wire [3:0] cmdHead,
  input wire busyOut,
  input wire drqOut,
  input wire intrPulse,
  input wire hostRdValid,
  input wire flashReq,
  input wire [7:0] flashSector,
  input wire idleMode,
  input wire autoPdEn,
  input wire [7:0] geoSpt,
  input wire [3:0] geoHeads
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire take = cmdValid && clkEn && !busyOut;
  reg verOn_r;
  // Flag changes on the take edge, the same edge a data phase could start
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      verOn_r <= 1'b0;
    else if (take)
      verOn_r <= cmdCode[7:1] == 7'h20;
  idle_done_a: assert property (
    take && cmdCode == 8'hE3 |=> busyOut ##1 !busyOut && intrPulse && idleMode)
    else $error("idle completion wrong");
  auto_pd_a: assert property (
    take && cmdCode == 8'hE3 |-> ##2 autoPdEn == ($past(cmdCount, 2) != 0))
    else $error("auto power-down state wrong");
  idle_imm_a: assert property (
    take && cmdCode == 8'hE1 |-> ##2 intrPulse && idleMode && !busyOut)
    else $error("idle immediate completion wrong");
  geometry_set_a: assert property (
    take && cmdCode == 8'h91 |-> ##2
      geoSpt == $past(cmdCount, 2) && geoHeads == $past(cmdHead, 2))
    else $error("geometry not stored");
  read_start_a: assert property (
    take && cmdCode[7:1] == 7'h10 |=> flashReq && flashSector == $past(cmdSector))
    else $error("read does not start at given sector");
  verify_quiet_a: assert property (
    verOn_r |-> !drqOut && !hostRdValid)
    else $error("verify moved data to host");
  recal_noop_a: assert property (
    take && cmdCode == 8'h10 |=> busyOut && !flashReq ##1 !busyOut && intrPulse)
    else $error("recalibrate not a plain completion");
  ident_phase_a: assert property (
    take && cmdCode == 8'hEC |=> busyOut && drqOut ##1 hostRdValid)
    else $error("identify data phase late");
endmodule
bind aci_engine aci_engine_asserts chk (.core_clk, .rst_n, .clkEn, .cmdValid,
  .cmdCode, .cmdCount, .cmdSector, .cmdHead, .busyOut, .drqOut, .intrPulse,
  .hostRdValid, .flashReq, .flashSector, .idleMode, .autoPdEn, .geoSpt,
  .geoHeads);
`default_nettype wire

// ### aci_flash_model.sv
// Flash stand-in: answers each sector request with 256 words.
// Assumes one request outstanding at a time.
`default_nettype none
// ==========
// Model
module aci_flash_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic flashReq,
  input wire logic [7:0] flashSector,
  output logic flashValid,
  output logic [15:0] flashData
);
  timeunit 1ns;
  timeprecision 1ns;
  int left;
  logic gap;
  logic [7:0] sec;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      left <= 0;
      gap <= 1'b0;
      sec <= 8'h00;
      flashValid <= 1'b0;
      flashData <= 16'h0000;
    end else begin
      flashValid <= 1'b0;
      // Stale data flips so it never passes for a real word
      flashData <= ~flashData;
      if (flashReq) begin
        left <= 256;
        sec <= flashSector;
      end else if (left > 0 && !gap) begin
        flashValid <= 1'b1;
        flashData <= {sec, 8'(256 - left)};
        left <= left - 1;
        gap <= slow;
      end else
        gap <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### aci_engine_test.sv
// Self-checking bench for the command engine.
// Assumes the checker binds itself and a flash stand-in feeds data.
`default_nettype none
// ==========
// Bench
module aci_engine_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] c, n; logic e, a;} aci_row_t;
  logic core_clk = 0, rst_n = 0, cmdValid = 0, slow = 0, chk = 0;
  logic clkEn = 1, hostWrValid = 0;
  logic secEnableIn = 0, smartEnableIn = 0;
  logic [7:0] cmdCode = 0, cmdFeature = 0, cmdCount = 0, cmdSector = 0;
  logic [3:0] cmdHead = 4'hF;
  logic [15:0] cmdCyl = 16'h1234, hostWrData = 16'h0000;
  wire busyOut, drqOut, dmaActOut, intrPulse, errOut, hostRdValid;
  wire flashReq, flashValid, idleMode, autoPdEn, userPwdActive, lockedOut;
  wire [15:0] hostRdData, flashData, flashCyl;
  wire [7:0] flashSector, geoSpt;
  wire [3:0] flashHead, geoHeads;
  logic [15:0] idw [256];
  int err_count = 0, tests_run = 0, nIntr, nWord, nDrq, nDma;
  aci_row_t rows [7] = '{'{8'hE3, 8'h07, 0, 1}, '{8'hE3, 8'h00, 0, 0},
    '{8'hE1, 8'h00, 0, 0}, '{8'h10, 8'h00, 0, 0}, '{8'h91, 8'h3F, 0, 0},
    '{8'hC8, 8'h01, 1, 0}, '{8'h00, 8'h00, 1, 0}};
  always #4 core_clk = ~core_clk;
  aci_engine #(.TOTAL_SECTORS(32'h0001_2345), .INTEGRITY_SIG(8'h5A)) DUT (
    .core_clk, .rst_n, .clkEn, .cmdValid, .cmdCode, .cmdFeature,
    .cmdCount, .cmdSector, .cmdCyl, .cmdHead, .hostWrValid,
    .hostWrData, .flashValid, .flashData, .flashEccErr(1'b0),
    .secEnableIn, .smartEnableIn, .busyOut, .drqOut, .dmaActOut, .intrPulse,
    .errOut, .hostRdValid, .hostRdData, .flashReq, .flashSector, .flashCyl,
    .flashHead, .idleMode, .autoPdEn, .geoSpt, .geoHeads, .userPwdActive,
    .lockedOut);
  aci_flash_model FM (.core_clk, .rst_n, .slow, .flashReq, .flashSector,
    .flashValid, .flashData);
  task automatic check(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Sampling on the falling edge keeps clear of the engine's own updates
  task automatic issue(input logic [7:0] c, f, n, s);
    int k;
    @(posedge core_clk);
    {cmdCode, cmdFeature, cmdCount, cmdSector} <= {c, f, n, s};
    cmdValid <= 1'b1;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    nIntr = 0;
    nWord = 0;
    nDrq = 0;
    nDma = 0;
    for (k = 0; k < 80000; k++) begin
      @(negedge core_clk);
      if (hostRdValid) begin
        if (nWord < 256)
          idw[nWord] = hostRdData;
        if (chk)
          check(hostRdData, {s + 8'(nWord / 256), 8'(nWord)});
        nWord++;
      end
      nIntr += int'(intrPulse);
      nDrq += int'(drqOut);
      nDma += int'(dmaActOut);
      if (!busyOut)
        break;
    end
    $display("command %h done", c);
    if (k == 80000) begin
      err_count++;
      tally_and_finish;
    end
  endtask
  // Password block: word 0 picks user, word 1 may differ from stored zero
  task automatic send_pwd(input logic [15:0] w1);
    int j;
    for (j = 0; j < 300 && !drqOut; j++)
      @(posedge core_clk);
    for (j = 0; j < 256; j++) begin
      @(posedge core_clk);
      hostWrValid <= 1'b1;
      hostWrData <= (j == 1) ? w1 : 16'h0000;
    end
    @(posedge core_clk);
    hostWrValid <= 1'b0;
  endtask
  initial begin
    int i;
    logic [7:0] cs;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[r]) begin
      issue(rows[r].c, 8'h00, rows[r].n, 8'h01);
      check(nIntr, 1);
      check(errOut, rows[r].e);
      check(autoPdEn, rows[r].a);
    end
    check({geoSpt, geoHeads}, 12'h3FF);
    issue(8'hEF, 8'h03, 8'h42, 8'h00);
    issue(8'hC6, 8'h00, 8'h02, 8'h00);
    issue(8'hEC, 8'h00, 8'h00, 8'h00);
    check(nWord, 256);
    check(idw[59], 16'h0102);
    check({idw[61], idw[60]}, 32'h0001_2345);
    check(idw[63], 16'h0007);
    check(idw[64], 16'h0003);
    for (i = 65; i < 69; i++)
      check(idw[i], 16'h0078);
    check({idw[80], idw[81]}, 32'h01FE_0021);
    check({idw[82], idw[83]}, 32'h0068_5000);
    check(idw[84], 16'h4000);
    check(idw[85], 16'h0008);
    check({idw[88][12:8], idw[88][4:0]}, 16'h009F);
    check(idw[128], 16'h0001);
    check(idw[255][7:0], 8'h5A);
    cs = 8'h00;
    for (i = 0; i < 256; i++)
      cs = cs + idw[i][15:8] + idw[i][7:0];
    check(cs, 8'h00);
    @(posedge core_clk);
    secEnableIn <= 1'b1;
    issue(8'hEF, 8'hAA, 8'h00, 8'h00);
    issue(8'hEC, 8'h00, 8'h00, 8'h00);
    check(idw[85], 16'h004A);
    chk = 1;
    slow <= 1'b1;
    issue(8'h20, 8'h00, 8'h02, 8'h01);
    check({nWord, nIntr}, {32'd512, 32'd2});
    check({flashCyl, flashHead, flashSector}, {16'h1234, 4'hF, 8'h03});
    check({nDrq != 0, nDma != 0}, 2'b10);
    issue(8'hC4, 8'h00, 8'h04, 8'h01);
    check({nWord, nIntr}, {32'd1024, 32'd2});
    issue(8'hC8, 8'h00, 8'h01, 8'h01);
    check({nWord, errOut}, {32'd256, 1'b0});
    check({nDrq != 0, nDma != 0}, 2'b01);
    chk = 0;
    slow <= 1'b0;
    issue(8'h40, 8'h00, 8'h02, 8'h01);
    check(nWord, 0);
    check(nDrq, 0);
    issue(8'h21, 8'h00, 8'h00, 8'h01);
    check({nWord, nIntr}, {32'd65536, 32'd256});
    fork
      issue(8'hF6, 8'h00, 8'h00, 8'h00);
      send_pwd(16'h0000);
    join
    check(errOut, 0);
    check({userPwdActive, lockedOut}, 0);
    fork
      issue(8'hF6, 8'h00, 8'h00, 8'h00);
      send_pwd(16'h0001);
    join
    check(errOut, 1);
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(negedge core_clk);
    check({busyOut, idleMode, autoPdEn, geoSpt}, 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
